// ==== usv_pkg.sv ====
package usv_pkg;
	// endpoint control register layout
	localparam int EP_STALL_BIT         = 1;
	// descriptor status word layout
	localparam int DESC_OWNER_BIT       = 15;
	localparam int DESC_STALL_EN_BIT    = 10;
	localparam int DESC_WIDTH           = 16;
	// usb_config_register_two layout
	localparam int CFG2_CMP_DIS_BIT     = 1;
	localparam int CFG2_CMP_SEL_BIT     = 0;
	// register map, word addresses
	localparam logic [7:0] ADDR_CFG2     = 8'h00;
	localparam logic [7:0] ADDR_VBUS     = 8'h01;
	localparam logic [7:0] ADDR_HOSTMODE = 8'h02;
	localparam logic [7:0] ADDR_EP_BASE  = 8'h10;
	localparam logic [7:0] ADDR_EP_MASK  = 8'hf0;
	localparam int         NUM_EP        = 16;
	localparam int         EP_IDX_W      = 4;
	localparam logic [7:0] CFG2_RESET    = 8'h00;
	localparam logic [7:0] EP_CTRL_RESET = 8'h00;

	// decoded vbus session state
	typedef enum logic [1:0] {
		VBUS_BELOW_SESS_END = 2'b00,
		VBUS_SESS_END_VALID = 2'b01,
		VBUS_SESS_VALID     = 2'b10,
		VBUS_ABOVE_VALID    = 2'b11
	} usv_vbus_type;

	// handshake answer chosen for a token
	typedef enum logic [1:0] {
		HS_NONE  = 2'b00,
		HS_ACK   = 2'b01,
		HS_NAK   = 2'b10,
		HS_STALL = 2'b11
	} usv_hs_type;
endpackage

// ==== usv_ep_if.sv ====
`timescale 1ns/1ps
// endpoint stall flag state shared between top and the stall decision
interface usv_ep_if #(parameter int NUM_EP = 16);
	logic [NUM_EP-1:0] stall_flag;
	logic [NUM_EP-1:0] sie_set;
	modport owner (output stall_flag, input sie_set);
	modport user  (input stall_flag, output sie_set);
endinterface

// ==== usv_vbus_decode.sv ====
`timescale 1ns/1ps
module usv_vbus_decode
	import usv_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic         clk_en,
	input  wire logic         cmp_sel,
	input  wire logic         cmp_a_meta,
	input  wire logic         cmp_b_meta,
	input  wire logic         vbus_vld_meta,
	input  wire logic         sess_vld_meta,
	input  wire logic         sess_end_meta,
	output usv_vbus_type      vbus_state,
	output logic              code_err
);
	logic [4:0]   sync_ff, nxt_sync;
	usv_vbus_type state_ff, nxt_state;
	logic         err_ff, nxt_err;

	// second synchroniser stage and table decode
	always_comb begin
		nxt_sync  = {cmp_a_meta, cmp_b_meta, vbus_vld_meta, sess_vld_meta, sess_end_meta};
		nxt_state = state_ff;
		nxt_err   = 1'b0;
		if (!cmp_sel) begin
			unique case (sync_ff[4:3])
				2'b00: nxt_state = VBUS_BELOW_SESS_END;
				2'b10: nxt_state = VBUS_SESS_END_VALID;
				2'b01: nxt_state = VBUS_SESS_VALID;
				2'b11: nxt_state = VBUS_ABOVE_VALID;
			endcase
		end else begin
			// illegal triples keep the last good state and raise an error level
			case (sync_ff[2:0])
				3'b001:  nxt_state = VBUS_BELOW_SESS_END;
				3'b000:  nxt_state = VBUS_SESS_END_VALID;
				3'b010:  nxt_state = VBUS_SESS_VALID;
				3'b110:  nxt_state = VBUS_ABOVE_VALID;
				default: nxt_err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sync_ff  <= '0;
			state_ff <= VBUS_BELOW_SESS_END;
			err_ff   <= 1'b0;
		end else if (clk_en) begin
			sync_ff  <= nxt_sync;
			state_ff <= nxt_state;
			err_ff   <= nxt_err;
		end
	end

	assign vbus_state = state_ff;
	assign code_err   = err_ff;
endmodule

// ==== usv_stall_ctrl.sv ====
`timescale 1ns/1ps
module usv_stall_ctrl
	import usv_pkg::*;
#(
	parameter int NUM_EP = 16
)(
	input  wire logic                  clk_sys,
	input  wire logic                  srst,
	input  wire logic                  clk_en,
	usv_ep_if.user                     ep,
	input  wire logic                  host_mode,
	input  wire logic                  tok_valid,
	input  wire logic [EP_IDX_W-1:0]   tok_ep,
	input  wire logic                  tok_is_in,
	input  wire logic [DESC_WIDTH-1:0] tok_desc,
	output usv_hs_type                 hs_code,
	output logic                       hs_valid,
	output logic [EP_IDX_W-1:0]        hs_ep
);
	usv_hs_type          hs_ff, nxt_hs;
	logic                vld_ff, nxt_vld;
	logic [EP_IDX_W-1:0] ep_ff, nxt_ep;
	logic                own, descriptor_stall_enable, flag;

	// nak and stall ignore direction; otherwise in tokens get no handshake and out tokens get an ack
	always_comb begin
		own     = tok_desc[DESC_OWNER_BIT];
		descriptor_stall_enable  = tok_desc[DESC_STALL_EN_BIT];
		flag    = ep.stall_flag[tok_ep];
		nxt_vld = tok_valid;
		nxt_ep  = tok_ep;
		ep.sie_set = '0;
		if (!tok_valid) begin
			nxt_hs = HS_NONE;
		end else if (host_mode) begin
			nxt_hs = tok_is_in ? HS_NONE : HS_ACK;
		end else if (!own) begin
			nxt_hs = HS_NAK;
		end else if (flag || descriptor_stall_enable) begin
			nxt_hs = HS_STALL;
			ep.sie_set[tok_ep] = descriptor_stall_enable;
		end else begin
			nxt_hs = tok_is_in ? HS_NONE : HS_ACK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hs_ff  <= HS_NONE;
			vld_ff <= 1'b0;
			ep_ff  <= '0;
		end else if (clk_en) begin
			hs_ff  <= nxt_hs;
			vld_ff <= nxt_vld;
			ep_ff  <= nxt_ep;
		end
	end

	assign hs_code  = hs_ff;
	assign hs_valid = vld_ff;
	assign hs_ep    = ep_ff;
endmodule

// ==== usv_top.sv ====
`timescale 1ns/1ps
module usv_top
	import usv_pkg::*;
#(
	parameter int NUM_EP = 16
)(
	input  wire logic                  clk_sys,
	input  wire logic                  srst,
	input  wire logic                  clk_en,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [7:0]                 reg_rdata,
	input  wire logic                  tok_valid,
	input  wire logic [EP_IDX_W-1:0]   tok_ep,
	input  wire logic                  tok_is_in,
	input  wire logic [DESC_WIDTH-1:0] tok_desc,
	output usv_hs_type                 hs_code,
	output logic                       hs_valid,
	output logic [EP_IDX_W-1:0]        hs_ep,
	input  wire logic                  comparator_state_in_a,
	input  wire logic                  comparator_state_in_b,
	input  wire logic                  vbus_valid_in,
	input  wire logic                  session_valid_in,
	input  wire logic                  session_end_in,
	input  wire usv_vbus_type          internal_vbus_state,
	output usv_vbus_type               vbus_state,
	output logic                       external_mode
);
	usv_ep_if #(.NUM_EP(NUM_EP)) ep_bus ();

	logic [7:0]        cfg2_ff, nxt_cfg2;
	logic              host_ff, nxt_host;
	logic [NUM_EP-1:0] stall_ff, nxt_stall;
	logic [7:0]        rdata_ff, nxt_rdata;
	logic [4:0]        pin_meta_ff;
	usv_vbus_type      ext_state;
	logic              ext_err;

	// word address decode for the endpoint control bank
	function automatic logic is_ep_addr(input logic [7:0] a);
		return (a & ADDR_EP_MASK) == ADDR_EP_BASE;
	endfunction

	// register writes; hardware set wins over a firmware clear in the same cycle
	always_comb begin
		nxt_cfg2  = cfg2_ff;
		nxt_host  = host_ff;
		nxt_stall = stall_ff;
		if (reg_wr && reg_addr == ADDR_CFG2)
			nxt_cfg2 = reg_wdata;
		if (reg_wr && reg_addr == ADDR_HOSTMODE)
			nxt_host = reg_wdata[0];
		if (reg_wr && is_ep_addr(reg_addr))
			nxt_stall[reg_addr[EP_IDX_W-1:0]] = reg_wdata[EP_STALL_BIT];
		nxt_stall = nxt_stall | ep_bus.sie_set;
	end

	// read mux, data valid the cycle after the strobe
	always_comb begin
		nxt_rdata = 8'h00;
		if (reg_rd) begin
			if (reg_addr == ADDR_CFG2)
				nxt_rdata = cfg2_ff;
			else if (reg_addr == ADDR_VBUS)
				nxt_rdata = {5'h00, ext_err, vbus_state};
			else if (reg_addr == ADDR_HOSTMODE)
				nxt_rdata = {7'h00, host_ff};
			else if (is_ep_addr(reg_addr))
				nxt_rdata[EP_STALL_BIT] = stall_ff[reg_addr[EP_IDX_W-1:0]];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cfg2_ff     <= CFG2_RESET;
			host_ff     <= 1'b0;
			stall_ff    <= '0;
			rdata_ff    <= 8'h00;
			pin_meta_ff <= '0;
		end else if (clk_en) begin
			cfg2_ff     <= nxt_cfg2;
			host_ff     <= nxt_host;
			stall_ff    <= nxt_stall;
			rdata_ff    <= nxt_rdata;
			pin_meta_ff <= {comparator_state_in_a, comparator_state_in_b,
				vbus_valid_in, session_valid_in, session_end_in};
		end
	end

	// stall flag drives the handshake decision, not just status
	assign ep_bus.stall_flag = stall_ff;

	usv_stall_ctrl #(.NUM_EP(NUM_EP)) u_stall (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.clk_en    (clk_en),
		.ep        (ep_bus.user),
		.host_mode (host_ff),
		.tok_valid (tok_valid),
		.tok_ep    (tok_ep),
		.tok_is_in (tok_is_in),
		.tok_desc  (tok_desc),
		.hs_code   (hs_code),
		.hs_valid  (hs_valid),
		.hs_ep     (hs_ep)
	);

	usv_vbus_decode u_vbus (
		.clk_sys       (clk_sys),
		.srst          (srst),
		.clk_en        (clk_en),
		.cmp_sel       (cfg2_ff[CFG2_CMP_SEL_BIT]),
		.cmp_a_meta    (pin_meta_ff[4]),
		.cmp_b_meta    (pin_meta_ff[3]),
		.vbus_vld_meta (pin_meta_ff[2]),
		.sess_vld_meta (pin_meta_ff[1]),
		.sess_end_meta (pin_meta_ff[0]),
		.vbus_state    (ext_state),
		.code_err      (ext_err)
	);

	// internal comparators are bypassed once disabled by software
	assign external_mode = cfg2_ff[CFG2_CMP_DIS_BIT];
	assign vbus_state    = external_mode ? ext_state : internal_vbus_state;
	assign reg_rdata     = rdata_ff;
endmodule

// ==== usv_top_chk.sv ====
`timescale 1ns/1ps
module usv_top_chk
	import usv_pkg::*;
(
	input wire logic                  clk_sys,
	input wire logic                  srst,
	input wire logic [7:0]            reg_addr,
	input wire logic [7:0]            reg_wdata,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire logic [7:0]            reg_rdata,
	input wire logic                  tok_valid,
	input wire logic [EP_IDX_W-1:0]   tok_ep,
	input wire logic                  tok_is_in,
	input wire logic [DESC_WIDTH-1:0] tok_desc,
	input wire usv_hs_type            hs_code,
	input wire logic                  hs_valid,
	input wire logic [EP_IDX_W-1:0]   hs_ep,
	input wire logic                  external_mode
);
	logic host_ff;
	logic nxt_host;
	// shadow of the host mode bit, which is not visible at the ports
	always_comb begin
		nxt_host = host_ff;
		if (reg_wr && reg_addr == ADDR_HOSTMODE)
			nxt_host = reg_wdata[0];
	end
	always_ff @(posedge clk_sys) begin
		host_ff <= srst ? 1'b0 : nxt_host;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	a_hs_ep: assert property (tok_valid |=> hs_valid && hs_ep == $past(tok_ep))
		else $error("handshake missing or wrong endpoint");
	a_no_spur: assert property (!tok_valid |=> !hs_valid)
		else $error("handshake without token");
	a_nak_owner: assert property (tok_valid && !tok_desc[DESC_OWNER_BIT] && !host_ff |=> hs_code == HS_NAK)
		else $error("owner clear not answered with nak");
	a_bit10_stall: assert property (tok_valid && !host_ff && tok_desc[DESC_OWNER_BIT] &&
		tok_desc[DESC_STALL_EN_BIT] |=> hs_code == HS_STALL) else $error("stall enable not stalled");
	a_host_out: assert property (tok_valid && host_ff && !tok_is_in |=> hs_code == HS_ACK)
		else $error("host mode out not acked");
	a_host_in: assert property (tok_valid && host_ff && tok_is_in |=> hs_code == HS_NONE)
		else $error("host mode in answered");
	a_ext_mode: assert property (reg_wr && reg_addr == ADDR_CFG2 |=>
		($past(reg_wdata) & 8'h02) == {6'h00, external_mode, 1'b0}) else $error("external mode wrong");
	a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
endmodule
bind usv_top usv_top_chk chk (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok_valid(tok_valid), .tok_ep(tok_ep),
	.tok_is_in(tok_is_in), .tok_desc(tok_desc), .hs_code(hs_code), .hs_valid(hs_valid), .hs_ep(hs_ep),
	.external_mode(external_mode));

// ==== usv_cmp_model.sv ====
`timescale 1ns/1ps
module usv_cmp_model (
	input  wire logic       sel,
	input  wire logic [1:0] level,
	output logic            a,
	output logic            b,
	output logic            vv,
	output logic            sv,
	output logic            se
);
	// all pins come from one level so a select change never sees a torn code
	always_comb begin
		a  = sel ? ~level[1] : level[0];
		b  = sel ? level[0] : level[1];
		vv = level == 2'b11;
		sv = level[1];
		se = level == 2'b00;
	end
endmodule

// ==== usv_endpoint_stall_vbus_decode_bench.sv ====
`timescale 1ns/1ps
module usv_endpoint_stall_vbus_decode_bench
	import usv_pkg::*;
;
	logic         clk_sys = 1'b0;
	logic         srst = 1'b1;
	logic [7:0]   reg_addr = 8'h00;
	logic [7:0]   reg_wdata = 8'h00;
	logic [7:0]   reg_rdata;
	logic         reg_wr = 1'b0;
	logic         reg_rd = 1'b0;
	logic         rd_d = 1'b0;
	logic         tok_valid = 1'b0;
	logic         tok_is_in = 1'b0;
	logic [3:0]   tok_ep = 4'h0;
	logic [3:0]   hs_ep;
	logic [15:0]  tok_desc = 16'h0000;
	logic [15:0]  seed = 16'h46ca;
	logic         hs_valid;
	logic         ext_mode;
	logic         cmp_sel = 1'b0;
	logic [1:0]   level = 2'b00;
	logic         pa, pb, pvv, psv, pse;
	usv_hs_type   hs_code;
	usv_vbus_type int_vbus = VBUS_BELOW_SESS_END;
	usv_vbus_type vbus_state;
	logic [7:0]   qrd[$];
	logic [5:0]   qhs[$];
	int           errors = 0;
	int           comparisons = 0;
	int           cyc = 0;
	usv_top dut (.clk_sys(clk_sys), .srst(srst), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok_valid(tok_valid), .tok_ep(tok_ep),
		.tok_is_in(tok_is_in), .tok_desc(tok_desc), .hs_code(hs_code), .hs_valid(hs_valid), .hs_ep(hs_ep),
		.comparator_state_in_a(pa), .comparator_state_in_b(pb), .vbus_valid_in(pvv), .session_valid_in(psv),
		.session_end_in(pse), .internal_vbus_state(int_vbus), .vbus_state(vbus_state), .external_mode(ext_mode));
	usv_cmp_model pm (.sel(cmp_sel), .level(level), .a(pa), .b(pb), .vv(pvv), .sv(psv), .se(pse));
	always #2.5 clk_sys = ~clk_sys;
	function automatic logic [15:0] xs(input logic [15:0] x);
		logic [15:0] y;
		y = x ^ (x << 7);
		y = y ^ (y >> 9);
		return y ^ (y << 8);
	endfunction
	task automatic close_out();
		// a note still queued is a result that never came out
		errors += qrd.size() + qhs.size();
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %0t %h %h", $time, e, g);
		end
	endtask
	task automatic chk_hs(input logic [5:0] e, input logic [5:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %0t %h %h", $time, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		qrd.push_back(e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask
	task automatic tok(input logic [3:0] ep, input logic in, input logic [15:0] desc, input usv_hs_type e);
		qhs.push_back({ep, e});
		@(posedge clk_sys);
		tok_valid <= 1'b1;
		tok_ep <= ep;
		tok_is_in <= in;
		tok_desc <= desc;
		@(posedge clk_sys);
		tok_valid <= 1'b0;
	endtask
	// results are matched in order against the notes left by the drivers
	always @(posedge clk_sys) begin
		rd_d <= reg_rd;
		// a result with no note left is compared against its own inverse so it always fails
		if (rd_d)
			chk_rd(qrd.size() > 0 ? qrd.pop_front() : ~reg_rdata, reg_rdata);
		if (hs_valid === 1'b1)
			chk_hs(qhs.size() > 0 ? qhs.pop_front() : ~{hs_ep, hs_code}, {hs_ep, hs_code});
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		rd(ADDR_CFG2, CFG2_RESET);
		rd(8'h13, EP_CTRL_RESET);
		wr(8'h05, 8'hff);
		rd(8'h05, 8'h00);
		// random endpoints with no flag set yet
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			tok(seed[3:0], i[0], {1'b0, seed[14:0]}, HS_NAK);
			tok(seed[7:4], i[0], 16'h8000, i[0] ? HS_NONE : HS_ACK);
		end
		wr(8'h13, 8'h02);
		rd(8'h13, 8'h02);
		tok(4'h3, 1'b1, 16'h8000, HS_STALL);
		tok(4'h3, 1'b0, 16'h8000, HS_STALL);
		tok(4'h3, 1'b0, 16'h0000, HS_NAK);
		tok(4'h5, 1'b1, 16'h8400, HS_STALL);
		rd(8'h15, 8'h02);
		tok(4'h5, 1'b0, 16'h8000, HS_STALL);
		wr(8'h15, 8'h00);
		tok(4'h5, 1'b0, 16'h8000, HS_ACK);
		wr(ADDR_HOSTMODE, 8'h01);
		tok(4'h3, 1'b1, 16'h8400, HS_NONE);
		tok(4'h3, 1'b0, 16'h8400, HS_ACK);
		wr(ADDR_HOSTMODE, 8'h00);
		// internal comparators stay in charge until the disable bit is set
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			int_vbus <= usv_vbus_type'(seed[1:0]);
			repeat (4) @(posedge clk_sys);
			rd(ADDR_VBUS, {6'h00, seed[1:0]});
		end
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_CFG2, {6'h00, 1'b1, s[0]});
			cmp_sel <= s[0];
			for (int l = 0; l < 4; l++) begin
				level <= l[1:0];
				repeat (5) @(posedge clk_sys);
				rd(ADDR_VBUS, {6'h00, l[1:0]});
			end
		end
		repeat (4) @(posedge clk_sys);
		close_out();
	end
endmodule
